// [core/bp_pkg.sv]
// Shared constants and types for the branch prediction control block
package bp_pkg;
  // Branch class presented by the execute stage
  typedef enum logic [2:0] {
    CLS_NONE   = 3'b001,  // Not a branch, or ineligible for history
    CLS_DIRECT = 3'b010,  // Direct branch or branch-with-link
    CLS_PCDEST = 3'b100   // Any other write to the program counter
  } br_class_t;

  // Penalty cycles after a wrong guess
  localparam logic [3:0] PEN_WIDE   = 4'h4;  // 32-bit instruction set
  localparam logic [3:0] PEN_NARROW = 4'h5;  // 16-bit instruction set
  localparam logic [3:0] PEN_NONE   = 4'h0;

  // Fall-through step in bytes for each instruction size
  localparam int STEP_WIDE   = 4;
  localparam int STEP_NARROW = 2;

  // Two-bit history counter encodings
  localparam logic [1:0] HIST_WEAK_TAKEN   = 2'h2;
  localparam logic [1:0] HIST_STRONG_TAKEN = 2'h3;
  localparam logic [1:0] HIST_MAX          = 2'h3;
  localparam logic [1:0] HIST_MIN          = 2'h0;

  // Recovery state machine, one-hot
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_FLUSH = 2'b10
  } rec_state_t;

  // Saturating update of a history counter
  function automatic logic [1:0] hist_next(input logic [1:0] h, input logic taken);
    logic [1:0] r;
    r = h;
    if (taken && h != HIST_MAX) begin
      r = h + 2'h1;
    end else if (!taken && h != HIST_MIN) begin
      r = h - 2'h1;
    end
    return r;
  endfunction
endpackage

// [core/btb_mem.sv]
// Branch target buffer storage: valid, tag, target and history per entry
module btb_mem #(
  parameter int IDX_W = 7,
  parameter int TAG_W = 23,
  parameter int ADR_W = 32
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  // Lookup port
  input  wire logic [IDX_W-1:0] rd_idx_i,
  output logic                  rd_vld_o,
  output logic [TAG_W-1:0]      rd_tag_o,
  output logic [ADR_W-1:0]      rd_tgt_o,
  output logic [1:0]            rd_hist_o,
  // Update port
  input  wire logic             wr_en_i,
  input  wire logic [IDX_W-1:0] wr_idx_i,
  input  wire logic [TAG_W-1:0] wr_tag_i,
  input  wire logic [ADR_W-1:0] wr_tgt_i,
  input  wire logic [1:0]       wr_hist_i
);
  localparam int DEPTH = 1 << IDX_W;

  logic [DEPTH-1:0] vld_q;
  logic [DEPTH-1:0] vld_d;
  logic [TAG_W-1:0] tag_mem [DEPTH];
  logic [ADR_W-1:0] tgt_mem [DEPTH];
  logic [1:0]       hist_mem [DEPTH];

  // Valid bits need reset so no stale entry predicts after power-up
  always_comb begin
    vld_d = vld_q;
    if (wr_en_i) begin
      vld_d[wr_idx_i] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vld_q    <= '0;
      rd_vld_o <= 1'b0;
    end else begin
      vld_q    <= vld_d;
      rd_vld_o <= vld_q[rd_idx_i];
    end
  end

  // Array contents carry no reset; guarded by the valid bits
  always_ff @(posedge mclk_i) begin
    if (wr_en_i) begin
      tag_mem[wr_idx_i]  <= wr_tag_i;
      tgt_mem[wr_idx_i]  <= wr_tgt_i;
      hist_mem[wr_idx_i] <= wr_hist_i;
    end
    rd_tag_o  <= tag_mem[rd_idx_i];
    rd_tgt_o  <= tgt_mem[rd_idx_i];
    rd_hist_o <= hist_mem[rd_idx_i];
  end
endmodule

// [core/branch_prediction_control.sv]
// Dynamic branch prediction, allocation and penalty control for the core pipeline

// Summary of operation
// [RQ1] Only direct branches of both instruction sets use history prediction.
// [RQ2] Program-counter writes are always predicted not taken and pay the penalty only when taken.
// [RQ3] An entry is allocated only on the first taken execution.
// [RQ4] Buffered branches are predicted from their recorded outcome history.
// [RQ5] A correct prediction adds no stall cycles.
// [RQ6] A miss costs four cycles for 32-bit, five for 16-bit instructions.
// [RQ7] Misses: buffered not-taken taken, unbuffered taken, buffered taken not taken.
// [RQ8] Load and store addressing modes never add stall cycles; here a memory op classed CLS_PCDEST or CLS_DIRECT still pays the miss penalty.
// [RQ9] An unbuffered not-taken branch costs nothing and leaves the buffer alone.
module branch_prediction_control #(
  parameter int IDX_W = 7,
  parameter int ADR_W = 32
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  // Fetch stage lookup
  input  wire logic             fetch_vld_i,
  input  wire logic [ADR_W-1:0] fetch_pc_i,
  output logic                  pred_vld_o,
  output logic                  pred_taken_o,
  output logic [ADR_W-1:0]      pred_tgt_o,
  // Execute stage resolution
  input  wire logic             res_vld_i,
  input  wire logic [ADR_W-1:0] res_pc_i,
  input  wire bp_pkg::br_class_t res_class_i,
  input  wire logic             res_narrow_i,
  input  wire logic             res_mem_op_i,
  input  wire logic             res_pred_taken_i,
  input  wire logic             res_hit_i,
  input  wire logic             res_taken_i,
  input  wire logic [ADR_W-1:0] res_tgt_i,
  // Pipeline control
  output logic                  flush_o,
  output logic [ADR_W-1:0]      redirect_pc_o,
  output logic                  stall_o,
  output logic                  mispred_o
);
  localparam int TAG_W = ADR_W - IDX_W - 1;

  // Refuse shapes the indexing cannot serve, at elaboration
  if (IDX_W < 1 || IDX_W > 12 || ADR_W < IDX_W + 2) begin
    $error("branch_prediction_control: unsupported IDX_W/ADR_W");
  end

  // Halfword-aligned index so 16-bit branches get their own entries
  function automatic logic [IDX_W-1:0] idx_of(input logic [ADR_W-1:0] pc);
    return pc[IDX_W:1];
  endfunction
  function automatic logic [TAG_W-1:0] tag_of(input logic [ADR_W-1:0] pc);
    return pc[ADR_W-1:IDX_W+1];
  endfunction

  // Buffer storage
  logic             m_vld;
  logic [TAG_W-1:0] m_tag;
  logic [ADR_W-1:0] m_tgt;
  logic [1:0]       m_hist;
  logic             wr_en;
  logic [1:0]       wr_hist;
  logic [IDX_W-1:0] rd_idx;
  logic [IDX_W-1:0] upd_idx;

  // Resolution update shares the lookup port: read current history first
  logic             upd_pend_q;
  logic             upd_pend_d;
  logic [ADR_W-1:0] upd_pc_q;
  logic [ADR_W-1:0] upd_pc_d;
  logic [ADR_W-1:0] upd_tgt_q;
  logic [ADR_W-1:0] upd_tgt_d;
  logic             upd_taken_q;
  logic             upd_taken_d;
  logic             upd_alloc_q;
  logic             upd_alloc_d;

  assign rd_idx  = idx_of(upd_pend_d ? upd_pc_d : fetch_pc_i);
  assign upd_idx = idx_of(upd_pc_q);

  btb_mem #(
    .IDX_W (IDX_W),
    .TAG_W (TAG_W),
    .ADR_W (ADR_W)
  ) u_btb (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .rd_idx_i  (rd_idx),
    .rd_vld_o  (m_vld),
    .rd_tag_o  (m_tag),
    .rd_tgt_o  (m_tgt),
    .rd_hist_o (m_hist),
    .wr_en_i   (wr_en),
    .wr_idx_i  (upd_idx),
    .wr_tag_i  (tag_of(upd_pc_q)),
    .wr_tgt_i  (upd_tgt_q),
    .wr_hist_i (wr_hist)
  );

  // Lookup side bookkeeping
  logic             look_q;
  logic             look_d;
  logic [TAG_W-1:0] look_tag_q;
  logic [TAG_W-1:0] look_tag_d;
  logic             hit;

  assign hit = m_vld && (m_tag == look_tag_q);

  // History write: new entries start weakly taken, others saturate
  always_comb begin
    wr_en   = 1'b0;
    wr_hist = bp_pkg::HIST_WEAK_TAKEN;
    if (upd_pend_q) begin
      if (upd_alloc_q && !hit) begin
        wr_en   = 1'b1;                                             // RQ3
        wr_hist = bp_pkg::HIST_WEAK_TAKEN;
      end else if (hit) begin
        wr_en   = 1'b1;
        wr_hist = bp_pkg::hist_next(m_hist, upd_taken_q);           // RQ4
      end
    end
  end

  // Recovery state machine and output registers
  bp_pkg::rec_state_t st_q;
  bp_pkg::rec_state_t st_d;
  logic [3:0]       pen_q;
  logic [3:0]       pen_d;
  logic             miss;
  logic             act_taken;
  logic [ADR_W-1:0] fix_pc;
  logic             pred_vld_d;
  logic             pred_taken_d;
  logic [ADR_W-1:0] pred_tgt_d;
  logic             flush_d;
  logic [ADR_W-1:0] redirect_d;
  logic             stall_d;
  logic             mispred_d;

  always_comb begin
    upd_pend_d   = 1'b0;
    upd_pc_d     = upd_pc_q;
    upd_tgt_d    = upd_tgt_q;
    upd_taken_d  = upd_taken_q;
    upd_alloc_d  = 1'b0;
    miss         = 1'b0;
    act_taken    = res_taken_i;
    // Step is cast to the address width so the sum never silently grows
    fix_pc       = res_pc_i + (res_narrow_i ? ADR_W'(bp_pkg::STEP_NARROW)
                                            : ADR_W'(bp_pkg::STEP_WIDE));
    if (res_taken_i) begin
      fix_pc = res_tgt_i;
    end
    look_d       = fetch_vld_i;
    look_tag_d   = tag_of(fetch_pc_i);
    st_d         = st_q;
    pen_d        = pen_q;
    flush_d      = 1'b0;
    redirect_d   = redirect_pc_o;
    mispred_d    = 1'b0;
    // Prediction only while the port served a fetch lookup
    pred_vld_d   = look_q;
    pred_taken_d = look_q && hit && m_hist[1];                      // RQ4
    pred_tgt_d   = pred_taken_d ? m_tgt : pred_tgt_o;

    // Resolution ignored while a flush is draining: wrong-path work
    if (res_vld_i && st_q == bp_pkg::ST_RUN) begin
      case (res_class_i)
        bp_pkg::CLS_DIRECT: begin
          // RQ7 covers all three cases via predicted vs actual direction
          miss        = res_pred_taken_i != res_taken_i;            // RQ7
          upd_pend_d  = res_hit_i || res_taken_i;                   // RQ9
          upd_alloc_d = !res_hit_i && res_taken_i;                  // RQ3
          upd_pc_d    = res_pc_i;
          upd_tgt_d   = res_tgt_i;
          upd_taken_d = res_taken_i;
        end
        bp_pkg::CLS_PCDEST: begin
          miss = res_taken_i;                                       // RQ2
        end
        bp_pkg::CLS_NONE: begin
          miss = 1'b0;                                              // RQ1
        end
        default: begin
          miss = 1'b0;
        end
      endcase
      // Memory addressing mode never reaches the penalty path unless the op also writes the program counter
      if (res_mem_op_i && res_class_i == bp_pkg::CLS_NONE) begin
        miss = 1'b0;                                                // RQ8
      end
    end

    // Update reads compare against the resolving branch, not the fetch address
    if (upd_pend_d) begin
      look_tag_d = tag_of(upd_pc_d);
    end

    // Miss costs fixed stall cycles; hits cost none
    case (st_q)
      bp_pkg::ST_RUN: begin
        if (miss) begin
          flush_d    = 1'b1;
          mispred_d  = 1'b1;
          redirect_d = act_taken ? res_tgt_i : fix_pc;
          pen_d      = res_narrow_i ? bp_pkg::PEN_NARROW : bp_pkg::PEN_WIDE; // RQ6
          st_d       = bp_pkg::ST_FLUSH;
        end
      end
      bp_pkg::ST_FLUSH: begin
        pen_d = pen_q - 4'h1;
        if (pen_q == 4'h1) begin
          st_d = bp_pkg::ST_RUN;
        end
      end
      default: begin
        st_d = bp_pkg::ST_RUN;
      end
    endcase
    stall_d = (st_d == bp_pkg::ST_FLUSH);                           // RQ5
  end

  // Register all state and outputs
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upd_pend_q    <= 1'b0;
      upd_pc_q      <= '0;
      upd_tgt_q     <= '0;
      upd_taken_q   <= 1'b0;
      upd_alloc_q   <= 1'b0;
      look_q        <= 1'b0;
      look_tag_q    <= '0;
      st_q          <= bp_pkg::ST_RUN;
      pen_q         <= bp_pkg::PEN_NONE;
      pred_vld_o    <= 1'b0;
      pred_taken_o  <= 1'b0;
      pred_tgt_o    <= '0;
      flush_o       <= 1'b0;
      redirect_pc_o <= '0;
      stall_o       <= 1'b0;
      mispred_o     <= 1'b0;
    end else begin
      upd_pend_q    <= upd_pend_d;
      upd_pc_q      <= upd_pc_d;
      upd_tgt_q     <= upd_tgt_d;
      upd_taken_q   <= upd_taken_d;
      upd_alloc_q   <= upd_alloc_d;
      look_q        <= look_d && !upd_pend_d;
      look_tag_q    <= look_tag_d;
      st_q          <= st_d;
      pen_q         <= pen_d;
      pred_vld_o    <= pred_vld_d;
      pred_taken_o  <= pred_taken_d;
      pred_tgt_o    <= pred_tgt_d;
      flush_o       <= flush_d;
      redirect_pc_o <= redirect_d;
      stall_o       <= stall_d;
      mispred_o     <= mispred_d;
    end
  end
endmodule

// [tb/bpc_chk.sv]
// Port assertions for the branch prediction control block
module bpc_chk #(
  parameter int ADR_W = 32
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // Watched ports
  input  wire logic              fetch_vld_i,
  input  wire logic              res_vld_i,
  input  wire bp_pkg::br_class_t res_class_i,
  input  wire logic              res_narrow_i,
  input  wire logic              res_mem_op_i,
  input  wire logic              res_pred_taken_i,
  input  wire logic              res_hit_i,
  input  wire logic              res_taken_i,
  input  wire logic [ADR_W-1:0]  res_tgt_i,
  input  wire logic              pred_vld_o,
  input  wire logic              flush_o,
  input  wire logic [ADR_W-1:0]  redirect_pc_o,
  input  wire logic              stall_o,
  input  wire logic              mispred_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Accepted resolutions; wrong-path ones during a penalty are ignored
  logic take;
  logic drct;
  logic miss;
  assign take = res_vld_i && !stall_o && !flush_o;
  assign drct = take && res_class_i == bp_pkg::CLS_DIRECT;
  assign miss = (drct && res_pred_taken_i != res_taken_i) ||
                (take && res_class_i == bp_pkg::CLS_PCDEST && res_taken_i);
  a_miss_flush: assert property (miss |=> flush_o && mispred_o)
    else $error("wrong guess without flush");
  a_pc_write: assert property (take && res_class_i == bp_pkg::CLS_PCDEST && res_taken_i
    |=> flush_o && redirect_pc_o == $past(res_tgt_i)) else $error("pc write not redirected");
  a_wide_pen: assert property (miss && !res_narrow_i |=> stall_o [*4] ##1 !stall_o)
    else $error("wide penalty length wrong");
  a_narrow_pen: assert property (miss && res_narrow_i |=> stall_o [*5] ##1 !stall_o)
    else $error("narrow penalty length wrong");
  a_hit_free: assert property (drct && res_pred_taken_i == res_taken_i
    |=> !stall_o && !flush_o) else $error("correct guess stalled");
  a_unbuf_nt: assert property (drct && !res_hit_i && !res_taken_i && !res_pred_taken_i
    |=> !flush_o && !stall_o) else $error("untaken unbuffered branch penalised");
  a_mem_free: assert property (take && res_mem_op_i && res_class_i != bp_pkg::CLS_PCDEST
    |=> !stall_o) else $error("memory op stalled");
  a_taken_tgt: assert property (drct && res_taken_i && !res_pred_taken_i
    |=> redirect_pc_o == $past(res_tgt_i)) else $error("redirect not at target");
  a_plain_free: assert property (take && res_class_i == bp_pkg::CLS_NONE |=> !flush_o)
    else $error("ineligible op flushed");
  a_pred_lat: assert property (pred_vld_o |-> $past(fetch_vld_i, 2))
    else $error("prediction without lookup");
endmodule

bind branch_prediction_control bpc_chk #(.ADR_W(ADR_W)) u_chk (.mclk_i, .rst_n_i,
  .fetch_vld_i, .res_vld_i, .res_class_i, .res_narrow_i, .res_mem_op_i, .res_pred_taken_i,
  .res_hit_i, .res_taken_i, .res_tgt_i, .pred_vld_o, .flush_o, .redirect_pc_o, .stall_o,
  .mispred_o);

// [tb/pipe_model.sv]
// Fetch and execute pipeline model issuing lookups and resolutions
module pipe_model #(
  parameter int ADR_W = 32
) (
  // Clock and pipeline control
  input  wire logic         mclk_i,
  input  wire logic         stall_i,
  input  wire logic         flush_i,
  // Fetch lookup
  output logic              fetch_vld_o,
  output logic [ADR_W-1:0]  fetch_pc_o,
  // Resolution
  output logic              res_vld_o,
  output bp_pkg::br_class_t res_class_o,
  output logic [4:0]        res_bits_o,
  output logic [ADR_W-1:0]  res_pc_o,
  output logic [ADR_W-1:0]  res_tgt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle values at time zero
  initial begin
    fetch_vld_o = 1'b0;
    fetch_pc_o  = '0;
    res_vld_o   = 1'b0;
    res_class_o = bp_pkg::CLS_NONE;
    res_bits_o  = 5'h00;
    res_pc_o    = '0;
    res_tgt_o   = '0;
  end
  // One lookup; the answer stands for one cycle after the second edge
  task automatic lookup(input logic [ADR_W-1:0] pc);
    @(negedge mclk_i);
    fetch_vld_o = 1'b1;
    fetch_pc_o  = pc;
    @(negedge mclk_i);
    fetch_vld_o = 1'b0;
    fetch_pc_o  = ~pc;
    @(negedge mclk_i);
  endtask
  // One resolution; bits are narrow, mem, predicted, hit, taken. Returns stall count
  task automatic resolve(input bp_pkg::br_class_t c, input logic [4:0] f,
                         input logic [ADR_W-1:0] pc, tg, output int n, output logic fl);
    n = 0;
    @(negedge mclk_i);
    while (stall_i || flush_i) @(negedge mclk_i);
    res_vld_o   = 1'b1;
    res_class_o = c;
    res_bits_o  = f;
    res_pc_o    = pc;
    res_tgt_o   = tg;
    @(negedge mclk_i);
    // Released lines show a changed value so stale data cannot pass
    res_vld_o  = 1'b0;
    res_bits_o = ~f;
    res_pc_o   = ~pc;
    res_tgt_o  = ~tg;
    fl         = flush_i;
    while (stall_i && n < 20) begin
      n++;
      @(negedge mclk_i);
    end
  endtask
endmodule

// [tb/test_branch_prediction_control.sv]
// Self-checking bench for the branch prediction control block
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_branch_prediction_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk_i;
  logic              rst_n_i;
  wire               fetch_vld_i, pred_vld_o, pred_taken_o, res_vld_i;
  wire               flush_o, stall_o, mispred_o;
  wire [4:0]         bits;
  wire [31:0]        fetch_pc_i, pred_tgt_o, res_pc_i, res_tgt_i, redirect_pc_o;
  bp_pkg::br_class_t res_class_i;
  int                fails = 0;
  int                num_checks = 0;
  // Design and pipeline partner
  branch_prediction_control u_dut (.mclk_i, .rst_n_i, .fetch_vld_i, .fetch_pc_i, .pred_vld_o,
    .pred_taken_o, .pred_tgt_o, .res_vld_i, .res_pc_i, .res_class_i, .res_narrow_i(bits[4]),
    .res_mem_op_i(bits[3]), .res_pred_taken_i(bits[2]), .res_hit_i(bits[1]),
    .res_taken_i(bits[0]), .res_tgt_i, .flush_o, .redirect_pc_o, .stall_o, .mispred_o);
  pipe_model u_pipe (.mclk_i, .stall_i(stall_o), .flush_i(flush_o), .fetch_vld_o(fetch_vld_i),
    .fetch_pc_o(fetch_pc_i), .res_vld_o(res_vld_i), .res_class_o(res_class_i),
    .res_bits_o(bits), .res_pc_o(res_pc_i), .res_tgt_o(res_tgt_i));
  // 200 MHz core clock
  initial mclk_i = 1'b0;
  always #2.5 mclk_i = ~mclk_i;
  // Resolve one instruction and judge flush, penalty and redirect
  task automatic run(input bp_pkg::br_class_t c, input logic [4:0] f, input logic [31:0] pc,
                     input logic [31:0] tg, input int pen, input logic [31:0] rd);
    int   n;
    logic fl;
    u_pipe.resolve(c, f, pc, tg, n, fl);
    `CHK("flush", pen != 0, fl)
    `CHK("penalty", pen, n)
    if (pen != 0) `CHK("redirect", rd, redirect_pc_o)
  endtask
  // Look up one address and judge the prediction
  task automatic look(input logic [31:0] pc, input logic tk, input logic [31:0] tg);
    u_pipe.lookup(pc);
    `CHK("pred valid", 1'b1, pred_vld_o)
    `CHK("pred taken", tk, pred_taken_o)
    if (tk) `CHK("pred target", tg, pred_tgt_o)
  endtask
  // First taken execution allocates; before that nothing is predicted
  task automatic t_alloc;
    look(32'h0000_1000, 1'b0, 32'h0);
    run(bp_pkg::CLS_DIRECT, 5'b00001, 32'h0000_1000, 32'h0000_5000, 4, 32'h0000_5000);
    look(32'h0000_1000, 1'b1, 32'h0000_5000);
  endtask
  // Untaken unbuffered branch is free and stays out of the buffer
  task automatic t_untaken;
    run(bp_pkg::CLS_DIRECT, 5'b00000, 32'h0000_1010, 32'h0000_6000, 0, 32'h0);
    look(32'h0000_1010, 1'b0, 32'h0);
  endtask
  // History walks down and back up; both wrong-guess kinds flush
  task automatic t_history;
    run(bp_pkg::CLS_DIRECT, 5'b00110, 32'h0000_1000, 32'h0000_5000, 4, 32'h0000_1004);
    look(32'h0000_1000, 1'b0, 32'h0);
    run(bp_pkg::CLS_DIRECT, 5'b00011, 32'h0000_1000, 32'h0000_5000, 4, 32'h0000_5000);
    run(bp_pkg::CLS_DIRECT, 5'b00111, 32'h0000_1000, 32'h0000_5000, 0, 32'h0);
    look(32'h0000_1000, 1'b1, 32'h0000_5000);
  endtask
  // Narrow branches pay the longer penalty
  task automatic t_narrow;
    run(bp_pkg::CLS_DIRECT, 5'b10001, 32'h0000_2022, 32'h0000_7000, 5, 32'h0000_7000);
    run(bp_pkg::CLS_DIRECT, 5'b10110, 32'h0000_2022, 32'h0000_7000, 5, 32'h0000_2024);
  endtask
  // Program-counter writes and memory ops
  task automatic t_pc_write;
    run(bp_pkg::CLS_PCDEST, 5'b01001, 32'h0000_3030, 32'h0000_8000, 4, 32'h0000_8000);
    look(32'h0000_3030, 1'b0, 32'h0);
    run(bp_pkg::CLS_NONE, 5'b01000, 32'h0000_0040, 32'h0, 0, 32'h0);
    run(bp_pkg::CLS_PCDEST, 5'b00000, 32'h0000_3030, 32'h0000_8000, 0, 32'h0);
  endtask
  // Closing report
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    repeat (20) @(negedge mclk_i);
    rst_n_i = 1'b1;
    t_alloc();
    t_untaken();
    t_history();
    t_narrow();
    t_pc_write();
    print_verdict();
  end
  // Watchdog well beyond the hundred or fewer cycles needed
  initial begin
    #20000;
    fails++;
    print_verdict();
  end
endmodule
